// ### common/msc_pkg.sv
package msc_pkg;
  // Register offsets and key addresses (byte offsets from base)
  localparam logic [10:0] OFF_CTRL_STATUS = 11'h000;
  localparam logic [10:0] OFF_IDENT_IRQ = 11'h004;
  localparam logic [10:0] OFF_DEADTIME = 11'h008;
  localparam logic [10:0] KEY_DT_ON = 11'h050;
  localparam logic [10:0] KEY_DT_OFF = 11'h054;
  localparam logic [10:0] KEY_RESET = 11'h060;
  localparam int ADDR_W = 11;

  // Set/clear flag vector: index 0..7 from bits 7..0, index 8..15 from bits 23..16
  localparam int JK_N = 16;
  localparam logic [15:0] JK_RESET = 16'h0800; // Software inhibit set, all else off
  localparam int JK_SET_LO = 0;
  localparam int JK_CLR_LO = 8;
  localparam int JK_SET_HI = 16;
  localparam int JK_CLR_HI = 24;

  // Status field positions
  localparam int ST_SRC_LSB = 28;
  localparam int ST_VME_IRQ = 27;
  localparam int ST_INT_IRQ = 26;
  localparam int ST_NEXT_EN = 15;
  localparam int ST_DT_EN = 13;
  localparam int ST_FIFO_LSB = 8;

  // Ident / interrupt control field positions
  localparam int ID_MOD_LSB = 16;
  localparam int ID_VER_LSB = 12;
  localparam int ID_IRQ_EN = 11;
  localparam int ID_LVL_LSB = 8;

  // Deadtime field positions
  localparam int DT_WIDTH_LSB = 8;
  localparam int DT_STEPS_W = 7;

  // Timing: 25 MHz clock, base step 120 ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_BASE_NS = 120;
  localparam int STEP_BASE_CYC = STEP_BASE_NS / CLK_PERIOD_NS;
  localparam int STEP_MAX_CYC = STEP_BASE_CYC * 8;
  localparam int SUB_W = $clog2(STEP_MAX_CYC);

  // Reset values of writable interrupt control and deadtime fields
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic [2:0] RST_IRQ_LVL = 3'h0;
  localparam logic [7:0] RST_IRQ_VEC = 8'h00;
  localparam logic [6:0] RST_DT_STEPS = 7'h00;
  localparam logic [1:0] RST_DT_WIDTH = 2'h0;

  // State of the deadtime engine
  typedef struct packed {
    logic busy;
    logic accept;
    logic [6:0] steps_left;
    logic [SUB_W-1:0] sub;
  } msc_dt_state_t;

  // State of the register block
  typedef struct packed {
    logic [15:0] jk;
    logic dt_mode;
    logic irq_en;
    logic [2:0] irq_lvl;
    logic [7:0] irq_vec;
    logic [6:0] dt_steps;
    logic [1:0] dt_width;
    logic [31:0] rdata;
    logic ack;
    logic irq_req;
    logic irq_acked;
    logic [2:0] inh_sync;
    logic [2:0] clr_sync;
    logic [2:0] nxt_sync;
    logic [2:0] hit_sync;
    logic count_en;
    logic ext_clear;
    logic ext_next;
  } msc_state_t;
endpackage

// ### rtl/msc_deadtime.sv
`timescale 1ns/100ps
module msc_deadtime (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [msc_pkg::DT_STEPS_W-1:0] steps,
  input wire logic [1:0] width,
  input wire logic hit,
  output logic accept_q,
  output logic busy_q
);
  import msc_pkg::*;

  msc_dt_state_t s_q, s_d;
  logic [SUB_W-1:0] step_cyc;

  // Step width in cycles: 3, 6, 12, 24 clocks for codes 0..3
  always_comb begin
    step_cyc = SUB_W'(STEP_BASE_CYC << width);
  end

  // Exact count, so the applied deadtime never falls short and has no excess
  always_comb begin
    s_d = s_q;
    s_d.accept = 1'b0;
    if (s_q.busy) begin
      if (s_q.sub == '0) begin
        if (s_q.steps_left == '0) begin
          s_d.busy = 1'b0;
        end else begin
          s_d.steps_left = s_q.steps_left - 7'h01;
          s_d.sub = step_cyc - SUB_W'(1);
        end
      end else begin
        s_d.sub = s_q.sub - SUB_W'(1);
      end
    end else if (hit) begin
      s_d.accept = 1'b1;
      // Steps plus one, each step_cyc long
      s_d.busy = enable;
      s_d.steps_left = steps;
      s_d.sub = step_cyc - SUB_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign accept_q = s_q.accept;
  assign busy_q = s_q.busy;
endmodule

// ### rtl/msc_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - Each function has its own set and clear bit; zeros leave state unchanged.
// - Reading offset 0x0 returns live status, not the last written value.
// - Interrupt sources 3..0 enabled by bits 23..20, disabled by bits 31..28.
// - Software counting inhibit set by bit 19, cleared by bit 27.
// - External inhibit, clear, advance enabled by bits 18..16, disabled by 26..24.
// - Broadcast handshake controller role on by bit 7, off by bit 15.
// - Broadcast participation on by bit 6, off by bit 14.
// - Input test mode bits 5/13; internal test pulses bits 4/12.
// - Input mode bits set by bits 3,2 and cleared by bits 11,10.
// - FIFO test mode enabled by bit 1, disabled by bit 9.
// - User lamp on by bit 0, off by bit 8.
// - Reset leaves all off except software inhibit, input mode zero.
// - Ident register bits 31..16 module number digits, 15..12 firmware version.
// - Bits 7..0 hold the vector, driven on D7..D0 during acknowledge.
// - Bits 10..8 select request level, bit 11 enables requests, all writable.
// - Deadtime register: steps in bits 6..0, width code in bits 9..8.
// - Width code 0..3 selects 120, 240, 480 or 960 ns steps.
// - Applied deadtime equals steps plus one times step width.
// - Deadtime never shorter than nominal; excess bounded per step width.
// - Any write to key 0x050 turns deadtime on, to 0x054 turns it off.
// - Status reads 0x80300 after reset (software inhibit in bit 19), 0x80100 with the larger FIFO.
module msc_regs #(
  parameter logic [15:0] MODULE_ID = 16'h1234, // Arbitrary value
  parameter logic [3:0] FW_VERSION = 4'h1 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [msc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata_q,
  output logic bus_ack_q,
  input wire logic iack,
  input wire logic [2:0] iack_level,
  input wire logic [3:0] irq_src,
  input wire logic [4:0] fifo_flags,
  input wire logic next_logic_en,
  input wire logic ext_inhibit,
  input wire logic ext_clear,
  input wire logic ext_next,
  input wire logic hit_in,
  output logic irq_req_q,
  output logic [2:0] irq_level_q,
  output logic [3:0] irq_src_en_q,
  output logic sw_inhibit_q,
  output logic ext_inhibit_en_q,
  output logic ext_clear_en_q,
  output logic ext_next_en_q,
  output logic hs_ctrl_q,
  output logic bcast_en_q,
  output logic in_test_q,
  output logic test_pulse_en_q,
  output logic [1:0] in_mode_q,
  output logic fifo_test_q,
  output logic lamp_q,
  output logic dt_mode_q,
  output logic count_en_q,
  output logic ext_clear_q,
  output logic ext_next_q,
  output logic hit_accept_q,
  output logic dt_busy_q
);
  import msc_pkg::*;

  msc_state_t s_q, s_d;
  logic [JK_N-1:0] jk_set;
  logic [JK_N-1:0] jk_clr;
  logic int_irq;
  logic vme_irq;
  logic [31:0] status;
  logic [31:0] ident;
  logic [31:0] deadtime_rd;
  logic wr_ctrl;
  logic wr_ident;
  logic wr_dt;
  logic key_reset;
  logic hit_edge;

  // Set and clear lanes of a control write, both halves of the word
  always_comb begin
    jk_set = {bus_wdata[JK_SET_HI +: 8], bus_wdata[JK_SET_LO +: 8]};
    jk_clr = {bus_wdata[JK_CLR_HI +: 8], bus_wdata[JK_CLR_LO +: 8]};
  end

  // Address decode; unmapped offsets are acknowledged but do nothing
  always_comb begin
    wr_ctrl = bus_wr && (bus_addr == OFF_CTRL_STATUS);
    wr_ident = bus_wr && (bus_addr == OFF_IDENT_IRQ);
    wr_dt = bus_wr && (bus_addr == OFF_DEADTIME);
    key_reset = bus_wr && (bus_addr == KEY_RESET);
  end

  // Internal flag reflects enabled sources; bus request also needs bit 11
  always_comb begin
    int_irq = |(irq_src & s_q.jk[15:12]);
    vme_irq = int_irq && s_q.irq_en;
  end

  // Status word assembled from live state, never from the last write
  always_comb begin
    status = '0;
    status[ST_SRC_LSB +: 4] = irq_src;
    status[ST_VME_IRQ] = vme_irq;
    status[ST_INT_IRQ] = int_irq;
    status[23:16] = s_q.jk[15:8];
    status[ST_NEXT_EN] = next_logic_en;
    status[ST_DT_EN] = s_q.dt_mode;
    status[ST_FIFO_LSB +: 5] = fifo_flags;
    status[7:0] = s_q.jk[7:0];
  end

  // Ident word: fixed upper fields, writable interrupt control below
  always_comb begin
    ident = '0;
    ident[ID_MOD_LSB +: 16] = MODULE_ID;
    ident[ID_VER_LSB +: 4] = FW_VERSION;
    ident[ID_IRQ_EN] = s_q.irq_en;
    ident[ID_LVL_LSB +: 3] = s_q.irq_lvl;
    ident[7:0] = s_q.irq_vec;
  end

  // Deadtime register is write only; the read path returns zero for it
  always_comb begin
    deadtime_rd = '0;
  end

  // Rising edge of the synchronised counting input
  always_comb begin
    hit_edge = s_q.hit_sync[1] && !s_q.hit_sync[2];
  end

  // Next-state logic for all register and pin state
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.rdata = '0;
    s_d.ext_clear = 1'b0;
    s_d.ext_next = 1'b0;

    // Set wins on a same-write conflict; the master must avoid that case
    if (wr_ctrl) begin
      s_d.jk = (s_q.jk | jk_set) & ~(jk_clr & ~jk_set);
    end
    if (wr_ident) begin
      s_d.irq_en = bus_wdata[ID_IRQ_EN];
      s_d.irq_lvl = bus_wdata[ID_LVL_LSB +: 3];
      s_d.irq_vec = bus_wdata[7:0];
    end
    // Taking new settings while deadtime runs is the master's hazard
    if (wr_dt) begin
      s_d.dt_steps = bus_wdata[DT_STEPS_W-1:0];
      s_d.dt_width = bus_wdata[DT_WIDTH_LSB +: 2];
    end
    if (bus_wr && (bus_addr == KEY_DT_ON)) begin
      s_d.dt_mode = 1'b1;
    end
    if (bus_wr && (bus_addr == KEY_DT_OFF)) begin
      s_d.dt_mode = 1'b0;
    end

    // Every strobe answers one cycle later
    if (bus_rd || bus_wr) begin
      s_d.ack = 1'b1;
    end
    if (bus_rd) begin
      case (bus_addr)
        OFF_CTRL_STATUS: s_d.rdata = status;
        OFF_IDENT_IRQ: s_d.rdata = ident;
        OFF_DEADTIME: s_d.rdata = deadtime_rd;
        default: s_d.rdata = '0;
      endcase
    end

    // Release on acknowledge: a matching acknowledge drops the request
    if (iack && s_q.irq_req && (iack_level == s_q.irq_lvl)) begin
      s_d.irq_acked = 1'b1;
      s_d.ack = 1'b1;
      s_d.rdata = {24'h000000, s_q.irq_vec};
    end else if (!vme_irq) begin
      s_d.irq_acked = 1'b0;
    end
    s_d.irq_req = vme_irq && !s_d.irq_acked;

    // Pin synchronisers, stage 0 feeds stage 1 only
    s_d.inh_sync = {s_q.inh_sync[1:0], ext_inhibit};
    s_d.clr_sync = {s_q.clr_sync[1:0], ext_clear};
    s_d.nxt_sync = {s_q.nxt_sync[1:0], ext_next};
    s_d.hit_sync = {s_q.hit_sync[1:0], hit_in};

    // Counting gate: software inhibit, plus the pin when its use is enabled
    s_d.count_en = !s_q.jk[11] && !(s_q.jk[10] && s_q.inh_sync[1]);
    s_d.ext_clear = s_q.jk[9] && s_q.clr_sync[1] && !s_q.clr_sync[2];
    s_d.ext_next = s_q.jk[8] && s_q.nxt_sync[1] && !s_q.nxt_sync[2];

    // Key reset returns the control state to its power-up values
    if (key_reset) begin
      s_d.jk = JK_RESET;
      s_d.dt_mode = 1'b0;
      s_d.irq_en = RST_IRQ_EN;
      s_d.irq_lvl = RST_IRQ_LVL;
      s_d.irq_vec = RST_IRQ_VEC;
      s_d.dt_steps = RST_DT_STEPS;
      s_d.dt_width = RST_DT_WIDTH;
      s_d.irq_req = 1'b0;
      s_d.irq_acked = 1'b0;
    end
  end

  // State register; power-up values match the key reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.jk <= JK_RESET;
      s_q.irq_en <= RST_IRQ_EN;
      s_q.irq_lvl <= RST_IRQ_LVL;
      s_q.irq_vec <= RST_IRQ_VEC;
      s_q.dt_steps <= RST_DT_STEPS;
      s_q.dt_width <= RST_DT_WIDTH;
    end else begin
      s_q <= s_d;
    end
  end

  // Deadtime engine, gated by the deadtime mode flag
  msc_deadtime u_deadtime (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(s_q.dt_mode),
    .steps(s_q.dt_steps),
    .width(s_q.dt_width),
    .hit(hit_edge),
    .accept_q(hit_accept_q),
    .busy_q(dt_busy_q)
  );

  // Outputs straight from state flops
  assign bus_rdata_q = s_q.rdata;
  assign bus_ack_q = s_q.ack;
  assign irq_req_q = s_q.irq_req;
  assign irq_level_q = s_q.irq_lvl;
  assign irq_src_en_q = s_q.jk[15:12];
  assign sw_inhibit_q = s_q.jk[11];
  assign ext_inhibit_en_q = s_q.jk[10];
  assign ext_clear_en_q = s_q.jk[9];
  assign ext_next_en_q = s_q.jk[8];
  assign hs_ctrl_q = s_q.jk[7];
  assign bcast_en_q = s_q.jk[6];
  assign in_test_q = s_q.jk[5];
  assign test_pulse_en_q = s_q.jk[4];
  assign in_mode_q = s_q.jk[3:2];
  assign fifo_test_q = s_q.jk[1];
  assign lamp_q = s_q.jk[0];
  assign dt_mode_q = s_q.dt_mode;
  assign count_en_q = s_q.count_en;
  assign ext_clear_q = s_q.ext_clear;
  assign ext_next_q = s_q.ext_next;
endmodule

// ### testbench/msc_master.sv
`timescale 1ns/100ps
module msc_master (
  input wire logic sys_clk,
  output logic [msc_pkg::ADDR_W-1:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata_q,
  input wire logic bus_ack_q
);
  import msc_pkg::*;
  // Idle bus at time zero
  initial begin
    bus_addr = 11'h000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 32'h0;
  end
  // One-cycle strobe; the answer is taken after the following edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic k);
    @(posedge sys_clk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    @(posedge sys_clk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = ~d; // Stale data must not look valid
    q = bus_rdata_q;
    k = bus_ack_q;
  endtask
endmodule

// ### testbench/msc_props.sv
`timescale 1ns/100ps
module msc_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [msc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata_q,
  input wire logic bus_ack_q,
  input wire logic [2:0] irq_level_q,
  input wire logic [3:0] irq_src_en_q,
  input wire logic sw_inhibit_q,
  input wire logic hs_ctrl_q,
  input wire logic lamp_q,
  input wire logic dt_mode_q,
  input wire logic hit_accept_q
);
  import msc_pkg::*;
  logic wc;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Write to the set/clear register
  assign wc = bus_wr && bus_addr == OFF_CTRL_STATUS;
  property p_ack; (bus_wr || bus_rd) |=> bus_ack_q; endproperty
  a_ack: assert property (p_ack) else $error("strobe not answered");
  property p_src;
    wc |=> irq_src_en_q == (($past(irq_src_en_q) & ~$past(bus_wdata[31:28])) | $past(bus_wdata[23:20]));
  endproperty
  a_src: assert property (p_src) else $error("source enables wrong");
  property p_inh; wc && bus_wdata[27] && !bus_wdata[19] |=> !sw_inhibit_q; endproperty
  a_inh: assert property (p_inh) else $error("inhibit not cleared");
  property p_lamp; wc && bus_wdata[0] |=> lamp_q; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not on");
  // Flags hold in any cycle without a write
  property p_hold; !bus_wr |=> $stable({irq_src_en_q, sw_inhibit_q, hs_ctrl_q, lamp_q}); endproperty
  a_hold: assert property (p_hold) else $error("flags moved without write");
  property p_rdst;
    bus_rd && bus_addr == OFF_CTRL_STATUS |=> bus_rdata_q[19] == sw_inhibit_q && bus_rdata_q[7] == hs_ctrl_q
      && bus_rdata_q[13] == dt_mode_q && bus_rdata_q[0] == lamp_q;
  endproperty
  a_rdst: assert property (p_rdst) else $error("status read mismatch");
  property p_dton; bus_wr && bus_addr == KEY_DT_ON |=> dt_mode_q; endproperty
  a_dton: assert property (p_dton) else $error("deadtime not on");
  property p_dtoff; bus_wr && bus_addr == KEY_DT_OFF |=> !dt_mode_q; endproperty
  a_dtoff: assert property (p_dtoff) else $error("deadtime not off");
  property p_lvl; bus_wr && bus_addr == OFF_IDENT_IRQ |=> irq_level_q == $past(bus_wdata[10:8]); endproperty
  a_lvl: assert property (p_lvl) else $error("level not written");
  // Shortest step is three cycles, so no accept for two after one
  property p_gap; hit_accept_q && dt_mode_q |=> !hit_accept_q [*2]; endproperty
  a_gap: assert property (p_gap) else $error("hit inside deadtime");
  property p_rst; bus_wr && bus_addr == KEY_RESET |=> sw_inhibit_q && !lamp_q && irq_src_en_q == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("key reset state wrong");
endmodule
bind msc_regs msc_props msc_props_inst (.sys_clk, .reset, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
  .bus_rdata_q, .bus_ack_q, .irq_level_q, .irq_src_en_q, .sw_inhibit_q, .hs_ctrl_q, .lamp_q,
  .dt_mode_q, .hit_accept_q);

// ### testbench/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import msc_pkg::*;
  localparam logic [15:0] MID = 16'h4321; // Arbitrary value
  localparam logic [3:0] FWV = 4'h7; // Arbitrary value
  logic sys_clk, reset, iack, hit_in, nle, ext_inhibit, ext_clear, ext_next, bus_wr, bus_rd, bus_ack_q, k;
  logic irq_req_q, dt_mode_q, hit_accept_q, dt_busy_q, count_en_q, ext_clear_q, ext_next_q;
  logic [2:0] iack_level, irq_level_q;
  logic [3:0] irq_src;
  logic [4:0] ff;
  logic [ADDR_W-1:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata_q, q, d;
  logic [15:0] f;
  int seed = 32'h0207;
  int n_fail, check_count, cyc, n, c, s;
  msc_regs #(.MODULE_ID(MID), .FW_VERSION(FWV)) msc_regs_inst (.sys_clk, .reset, .bus_addr, .bus_wr,
    .bus_rd, .bus_wdata, .bus_rdata_q, .bus_ack_q, .iack, .iack_level, .irq_src, .fifo_flags(ff),
    .next_logic_en(nle), .ext_inhibit, .ext_clear, .ext_next, .hit_in, .irq_req_q, .irq_level_q,
    .irq_src_en_q(), .sw_inhibit_q(), .ext_inhibit_en_q(), .ext_clear_en_q(), .ext_next_en_q(),
    .hs_ctrl_q(), .bcast_en_q(), .in_test_q(), .test_pulse_en_q(), .in_mode_q(), .fifo_test_q(),
    .lamp_q(), .dt_mode_q, .count_en_q, .ext_clear_q, .ext_next_q, .hit_accept_q, .dt_busy_q);
  msc_master msc_master_inst (.sys_clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata_q, .bus_ack_q);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Status image: flags hold bits 23..16 above bits 7..0
  function automatic logic [31:0] st(input logic [15:0] g, input logic dt);
    st = {8'h00, g[15:8], nle, 1'b0, dt, ff, g[7:0]};
  endfunction
  function automatic logic [15:0] jk(input logic [15:0] g, input logic [31:0] w);
    jk = (g & ~{w[31:24], w[15:8]}) | {w[23:16], w[7:0]};
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] w);
    msc_master_inst.xfer(1'b1, a, w, q, k);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    msc_master_inst.xfer(1'b0, a, 32'h0, q, k);
    `CHK(k, 1'b1)
    `CHK(q, e)
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the longest deadtime run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    {reset, iack, hit_in, nle, ext_inhibit, ext_clear, ext_next} = 7'h40;
    iack_level = 3'h0;
    irq_src = 4'h0;
    ff = 5'h03;
    f = 16'h0800;
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rd(OFF_CTRL_STATUS, st(f, 1'b0));
    // Walk each bit alone, then random words that never set and clear one flag
    for (n = 0; n < 150; n++) begin
      d = $random(seed);
      d = d & ~{d[23:16], 8'h00, d[7:0], 8'h00};
      if (n < 32) d = 32'h1 << n;
      {ext_inhibit, ext_clear, ext_next, nle} = 4'($random(seed));
      ff = 5'($random(seed));
      wr(OFF_CTRL_STATUS, d);
      f = jk(f, d);
      rd(OFF_CTRL_STATUS, st(f, 1'b0));
      `CHK(count_en_q, !f[11] && !(f[10] && ext_inhibit))
    end
    // Pin pulses: none while pin use is off, exactly one per rising edge once on
    for (n = 0; n < 2; n++) begin
      {ext_clear, ext_next} = 2'b00;
      d = n ? 32'h00030000 : 32'h03000000;
      wr(OFF_CTRL_STATUS, d);
      f = jk(f, d);
      repeat (4) @(posedge sys_clk);
      #1;
      {ext_clear, ext_next} = 2'b11;
      c = 0;
      s = 0;
      for (int i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        #1;
        c += ext_clear_q;
        s += ext_next_q;
      end
      `CHK(c, n)
      `CHK(s, n)
    end
    d = $random(seed);
    wr(OFF_IDENT_IRQ, d);
    rd(OFF_IDENT_IRQ, {MID, FWV, d[11:0]});
    rd(OFF_DEADTIME, 32'h0);
    wr(OFF_IDENT_IRQ, 32'h00000b5a);
    wr(OFF_CTRL_STATUS, 32'h00100000);
    f = jk(f, 32'h00100000);
    irq_src = 4'h1;
    // Sample after the edge has settled, never in its own time step
    for (c = 0; c < 20 && irq_req_q !== 1'b1; c++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(irq_req_q, 1'b1)
    `CHK(irq_level_q, 3'h3)
    rd(OFF_CTRL_STATUS, st(f, 1'b0) | 32'h1c000000);
    // Wrong level first: no answer, request stands
    iack_level = 3'h2;
    iack = 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK(bus_ack_q, 1'b0)
    `CHK(irq_req_q, 1'b1)
    iack_level = 3'h3;
    @(posedge sys_clk);
    #1;
    iack = 1'b0;
    `CHK(bus_ack_q, 1'b1)
    `CHK(bus_rdata_q[7:0], 8'h5a)
    `CHK(irq_req_q, 1'b0)
    irq_src = 4'h0;
    // Each step width; the widest with 63 steps
    for (n = 0; n < 4; n++) begin
      s = (n == 3) ? 63 : {$random(seed)} % 8;
      wr(KEY_DT_OFF, 32'h0);
      wr(OFF_DEADTIME, {22'h0, n[1:0], 1'b0, s[6:0]});
      wr(KEY_DT_ON, 32'h0);
      rd(OFF_CTRL_STATUS, st(f, 1'b1));
      hit_in = 1'b1;
      // Accept is a one-cycle pulse, so look after each edge has settled
      for (c = 0; c < 10 && hit_accept_q !== 1'b1; c++) begin
        @(posedge sys_clk);
        #1;
      end
      hit_in = 1'b0;
      `CHK(hit_accept_q, 1'b1)
      c = dt_busy_q ? 1 : 0;
      for (int i = 0; i < ((s + 1) * 3 << n) + 8; i++) begin
        @(posedge sys_clk);
        #1;
        if (dt_busy_q) c++;
      end
      `CHK(c, (s + 1) * 3 << n)
    end
    wr(KEY_DT_OFF, 32'h0);
    rd(OFF_CTRL_STATUS, st(f, 1'b0));
    wr(OFF_CTRL_STATUS, 32'h00ff00ff);
    wr(KEY_RESET, 32'h0);
    rd(OFF_CTRL_STATUS, st(16'h0800, 1'b0));
    rd(OFF_IDENT_IRQ, {MID, FWV, 12'h000});
    print_verdict;
  end
endmodule
